// ==== ias_pkg.sv ====
// Constants, types and reset values for the network address source selector.
// Assumes a single clock and a synchronous active-high control-power reset.
// What this block does
// R1: Fourth octet comes from two hex switches weighted sixteen and one.
// R2: Switches at zero defer to stored parameters or DHCP per the source selection.
// R3: Switch values 01h to FEh are used directly as the fourth octet.
// R4: Switches at FFh force address 192.168.1.1 regardless of parameters and DHCP.
// R5: A switch change takes effect only after control power is cycled.
// R6: Another node using our address raises a duplicate address error.
// R7: With switches supplying the octet, mask and gateway come from stored parameters.
// R8: Four mask octets, 0 to 255, reset to 255, 255, 255, 0.
// R9: Four gateway octets, 0 to 255, all reset to zero.
// R10: Source selection: 0 means parameters, 2 means DHCP, reset value 2.
// R11: Four address octets, 0 to 255, reset to 192, 168, 1, 1.
// R12: Full-address mode takes address, mask and gateway from one source only.
// R13: Operator sets switches to zero and selection to 0 for parameter addressing.
// R14: Switches zero and DHCP selected take address, mask, gateway from DHCP.
// R15: A DHCP lease is discarded when control power is removed.
// R16: Switches are sampled once after reset and held for the power-on period.
package ias_pkg;

  typedef logic [3:0][7:0] ias_quad_type;

  typedef struct packed {
    ias_quad_type ip;
    ias_quad_type mask;
    ias_quad_type gw;
  } ias_addr_set_type;

  typedef struct packed {
    logic             valid;
    ias_addr_set_type set;
  } ias_lease_type;

  typedef struct packed {
    logic         valid;
    ias_quad_type sender_ip;
  } ias_peer_type;

  typedef enum logic [4:0] {
    IAS_SRC_NONE   = 5'h01,
    IAS_SRC_SWITCH = 5'h02,
    IAS_SRC_FIXED  = 5'h04,
    IAS_SRC_PARAM  = 5'h08,
    IAS_SRC_DHCP   = 5'h10
  } ias_src_type;

  localparam logic [7:0]   IAS_SEL_PARAM   = 8'h00;
  localparam logic [7:0]   IAS_SEL_DHCP    = 8'h02;
  localparam logic [7:0]   IAS_SEL_RESET   = 8'h02;
  localparam logic [7:0]   IAS_SW_DEFER    = 8'h00;
  localparam logic [7:0]   IAS_SW_FIXED    = 8'hff;
  localparam ias_quad_type IAS_HOST_RESET  = {8'hc0, 8'ha8, 8'h01, 8'h01};
  localparam ias_quad_type IAS_MASK_RESET  = {8'hff, 8'hff, 8'hff, 8'h00};
  localparam ias_quad_type IAS_GW_RESET    = {8'h00, 8'h00, 8'h00, 8'h00};
  localparam ias_quad_type IAS_FIXED_IP    = {8'hc0, 8'ha8, 8'h01, 8'h01};

  localparam logic [7:0]   IAS_OFF_SEL     = 8'h00;
  localparam logic [7:0]   IAS_OFF_STATUS  = 8'h04;
  localparam logic [7:0]   IAS_OFF_IRQMASK = 8'h08;
  localparam logic [7:0]   IAS_OFF_INFO    = 8'h0c;
  localparam logic [7:0]   IAS_OFF_HOST    = 8'h10;
  localparam logic [7:0]   IAS_OFF_MASK    = 8'h20;
  localparam logic [7:0]   IAS_OFF_GW      = 8'h30;
  localparam logic [7:0]   IAS_OFF_ACT_IP  = 8'h40;
  localparam logic [7:0]   IAS_OFF_ACT_MSK = 8'h44;
  localparam logic [7:0]   IAS_OFF_ACT_GW  = 8'h48;
  localparam logic [7:0]   IAS_GROUP_MASK  = 8'hf0;

  localparam int unsigned  IAS_ST_CONFLICT = 0;
  localparam int unsigned  IAS_ST_LEASE    = 1;
  localparam int unsigned  IAS_ST_W        = 2;

  typedef struct packed {
    logic [7:0]            sel;
    ias_quad_type          host;
    ias_quad_type          mask;
    ias_quad_type          gw;
    logic [7:0]            sw;
    logic                  sw_taken;
    ias_lease_type         lease;
    logic [IAS_ST_W-1:0]   status;
    logic [IAS_ST_W-1:0]   irq_mask;
    logic                  ack;
    logic [31:0]           rdata;
    ias_addr_set_type      active;
    logic                  active_valid;
    ias_src_type           src;
  } ias_state_type;

  localparam ias_state_type IAS_STATE_RESET = '{
    sel:          IAS_SEL_RESET,
    host:         IAS_HOST_RESET,
    mask:         IAS_MASK_RESET,
    gw:           IAS_GW_RESET,
    sw:           8'h00,
    sw_taken:     1'b0,
    lease:        '0,
    status:       '0,
    irq_mask:     '0,
    ack:          1'b0,
    rdata:        32'h0000_0000,
    active:       '0,
    active_valid: 1'b0,
    src:          IAS_SRC_NONE
  };

endpackage

// ==== ias_address_select.sv ====
// Network address source selector with a classic Wishbone register slave.
// Assumes switch, lease and peer inputs are synchronous to clk_i; rst_i is the control-power reset.
//
// Implementation choices: the address map and the Wishbone register port.
`timescale 1ns/1ps
module ias_address_select
  import ias_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Rotary switches and network side.
  input  wire logic [7:0]       octet_selector_switches_i,
  input  wire ias_lease_type    dhcp_lease_i,
  input  wire ias_peer_type     peer_i,
  // Resolved configuration.
  output ias_addr_set_type      active_o,
  output logic                  active_valid_o,
  output ias_src_type           active_src_o,
  output logic                  dhcp_enable_o,
  output logic                  duplicate_host_error_o,
  output logic                  irq_o
);

  ias_state_type    st;
  ias_state_type    next_st;
  logic             req;
  logic             dhcp_mode;
  logic [1:0]       oct_idx;
  logic [31:0]      rd;
  logic [IAS_ST_W-1:0] events;
  ias_addr_set_type res_set;
  logic             res_valid;
  ias_src_type      res_src;

  always_comb begin
    next_st   = st;
    req       = wb_cyc_i & wb_stb_i & ~st.ack;
    oct_idx   = 2'd3 - wb_adr_i[3:2];
    dhcp_mode = (st.sw == IAS_SW_DEFER) && (st.sel == IAS_SEL_DHCP);
    rd        = 32'h0000_0000;
    events    = '0;
    res_set   = '0;
    res_valid = 1'b0;
    res_src   = IAS_SRC_NONE;

    // Switches are caught once after reset and then frozen.
    if (!st.sw_taken) begin // R16 R5
      next_st.sw       = octet_selector_switches_i;
      next_st.sw_taken = 1'b1;
    end

    // Source resolution from the frozen switch value.
    if (st.sw_taken) begin
      if (st.sw == IAS_SW_FIXED) begin // R4
        res_set.ip   = IAS_FIXED_IP;
        res_set.mask = st.mask;
        res_set.gw   = st.gw;
        res_valid    = 1'b1;
        res_src      = IAS_SRC_FIXED;
      end else if (st.sw != IAS_SW_DEFER) begin // R1 R3 R7
        res_set.ip   = {st.host[3], st.host[2], st.host[1], st.sw};
        res_set.mask = st.mask;
        res_set.gw   = st.gw;
        res_valid    = 1'b1;
        res_src      = IAS_SRC_SWITCH;
      end else if (st.sel == IAS_SEL_PARAM) begin // R2 R12 R13
        res_set.ip   = st.host;
        res_set.mask = st.mask;
        res_set.gw   = st.gw;
        res_valid    = 1'b1;
        res_src      = IAS_SRC_PARAM;
      end else if (st.lease.valid) begin // R12 R14
        res_set      = st.lease.set;
        res_valid    = 1'b1;
        res_src      = IAS_SRC_DHCP;
      end
    end
    next_st.active       = res_set;
    next_st.active_valid = res_valid;
    next_st.src          = res_src;

    // Leases are only taken in DHCP mode and are lost on reset.
    if (dhcp_mode && dhcp_lease_i.valid) begin // R14 R15
      next_st.lease.valid = 1'b1;
      next_st.lease.set   = dhcp_lease_i.set;
      events[IAS_ST_LEASE] = 1'b1;
    end
    if (peer_i.valid && st.active_valid && (peer_i.sender_ip == st.active.ip)) begin // R6
      events[IAS_ST_CONFLICT] = 1'b1;
    end

    // Register read mux.
    if (wb_adr_i == IAS_OFF_SEL) begin
      rd[7:0] = st.sel;
    end else if (wb_adr_i == IAS_OFF_STATUS) begin
      rd[IAS_ST_W-1:0] = st.status;
    end else if (wb_adr_i == IAS_OFF_IRQMASK) begin
      rd[IAS_ST_W-1:0] = st.irq_mask;
    end else if (wb_adr_i == IAS_OFF_INFO) begin
      rd = {16'h0000, st.sw, 3'b000, st.src};
    end else if ((wb_adr_i & IAS_GROUP_MASK) == IAS_OFF_HOST) begin
      rd[7:0] = st.host[oct_idx];
    end else if ((wb_adr_i & IAS_GROUP_MASK) == IAS_OFF_MASK) begin
      rd[7:0] = st.mask[oct_idx];
    end else if ((wb_adr_i & IAS_GROUP_MASK) == IAS_OFF_GW) begin
      rd[7:0] = st.gw[oct_idx];
    end else if (wb_adr_i == IAS_OFF_ACT_IP) begin
      rd = st.active.ip;
    end else if (wb_adr_i == IAS_OFF_ACT_MSK) begin
      rd = st.active.mask;
    end else if (wb_adr_i == IAS_OFF_ACT_GW) begin
      rd = st.active.gw;
    end

    next_st.ack    = req;
    next_st.status = st.status;
    if (req) begin
      next_st.rdata = wb_we_i ? 32'h0000_0000 : rd;
      if (!wb_we_i && (wb_adr_i == IAS_OFF_STATUS)) begin
        next_st.status = '0;
      end
      if (wb_we_i && wb_sel_i[0]) begin
        if (wb_adr_i == IAS_OFF_SEL) begin
          // Only the two documented encodings are accepted.
          if ((wb_dat_i[7:0] == IAS_SEL_PARAM) || (wb_dat_i[7:0] == IAS_SEL_DHCP)) begin // R10
            next_st.sel = wb_dat_i[7:0];
          end
        end else if (wb_adr_i == IAS_OFF_IRQMASK) begin
          next_st.irq_mask = wb_dat_i[IAS_ST_W-1:0];
        end else if ((wb_adr_i & IAS_GROUP_MASK) == IAS_OFF_HOST) begin // R11
          next_st.host[oct_idx] = wb_dat_i[7:0];
        end else if ((wb_adr_i & IAS_GROUP_MASK) == IAS_OFF_MASK) begin // R8
          next_st.mask[oct_idx] = wb_dat_i[7:0];
        end else if ((wb_adr_i & IAS_GROUP_MASK) == IAS_OFF_GW) begin // R9
          next_st.gw[oct_idx] = wb_dat_i[7:0];
        end
      end
    end
    // A new event wins over a clearing read in the same cycle.
    next_st.status = next_st.status | events;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= IAS_STATE_RESET; // R8 R9 R10 R11 R15
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o               = st.rdata;
  assign wb_ack_o               = st.ack;
  assign active_o               = st.active;
  assign active_valid_o         = st.active_valid;
  assign active_src_o           = st.src;
  assign dhcp_enable_o          = (st.sw == IAS_SW_DEFER) && st.sw_taken && (st.sel == IAS_SEL_DHCP);
  assign duplicate_host_error_o = st.status[IAS_ST_CONFLICT];
  assign irq_o                  = |(st.status & st.irq_mask);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_fixed_address: assert property (st.sw_taken && st.sw == IAS_SW_FIXED |=> // R4
    active_o.ip == IAS_FIXED_IP && active_src_o == IAS_SRC_FIXED)
    else $error("fixed address not applied");
  chk_switch_octet: assert property (st.sw_taken && st.sw != IAS_SW_FIXED && st.sw != IAS_SW_DEFER |=> // R3
    active_o.ip[0] == $past(st.sw) && active_src_o == IAS_SRC_SWITCH)
    else $error("switch octet not used");
  chk_switch_mask: assert property (st.sw_taken && st.sw != IAS_SW_DEFER |=> // R7
    active_o.mask == $past(st.mask) && active_o.gw == $past(st.gw))
    else $error("mask or gateway not from parameters");
  chk_param_source: assert property (st.sw_taken && st.sw == IAS_SW_DEFER && st.sel == IAS_SEL_PARAM |=> // R2
    active_o.ip == $past(st.host) && active_src_o == IAS_SRC_PARAM)
    else $error("parameter address not applied");
  chk_dhcp_source: assert property (dhcp_mode && st.lease.valid |=> // R14
    active_o == $past(st.lease.set) && active_src_o == IAS_SRC_DHCP)
    else $error("dhcp lease not applied");
  chk_switch_frozen: assert property (st.sw_taken |=> $stable(st.sw) && st.sw_taken) // R5
    else $error("switch value changed while powered");
  chk_switch_sample: assert property (!st.sw_taken |=> st.sw_taken && st.sw == $past(octet_selector_switches_i)) // R16
    else $error("switches not sampled after reset");
  chk_conflict_flag: assert property (peer_i.valid && st.active_valid && peer_i.sender_ip == st.active.ip // R6
    |=> duplicate_host_error_o)
    else $error("address conflict not flagged");
  chk_lease_dropped: assert property (disable iff (1'b0) rst_i |=> !st.lease.valid && st.sel == IAS_SEL_RESET) // R15
    else $error("lease survived reset");
  chk_param_reset: assert property (disable iff (1'b0) rst_i |=> // R8
    st.mask == IAS_MASK_RESET && st.gw == IAS_GW_RESET && st.host == IAS_HOST_RESET)
    else $error("parameter reset value wrong");
  chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack timing wrong");

  cov_fixed: cover property (active_src_o == IAS_SRC_FIXED);
  cov_dhcp: cover property (dhcp_lease_i.valid && dhcp_mode ##1 active_src_o == IAS_SRC_DHCP);
  cov_conflict: cover property ($rose(duplicate_host_error_o));
  cov_irq: cover property ($rose(irq_o));

endmodule

// ==== ias_net_model.sv ====
// Far side: a DHCP server granting leases and another node announcing its address.
// Assumes the bench commands it synchronously to clk_i.
`timescale 1ns/1ps
module ias_net_model
  import ias_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Commands from the bench.
  input  wire logic             dhcp_enable_i,
  input  wire logic             offer_i,
  input  wire ias_addr_set_type offer_set_i,
  input  wire logic             announce_i,
  input  wire ias_quad_type     announce_ip_i,
  // Network side.
  output ias_lease_type         lease_o,
  output ias_peer_type          peer_o
);
  // Idle payloads flip every cycle so that a stale value is never mistaken for data.
  always @(posedge clk_i) begin
    if (rst_i) begin
      lease_o <= '0;
      peer_o  <= '0;
    end else begin
      lease_o <= '{valid: offer_i && dhcp_enable_i, set: offer_i ? offer_set_i : ~lease_o.set};
      peer_o  <= '{valid: announce_i, sender_ip: announce_i ? announce_ip_i : ~peer_o.sender_ip};
    end
  end
endmodule

// ==== ias_address_select_bench.sv ====
// Self-checking bench for the address source selector.
// Assumes the design and the network model share one 250 MHz clock.
`timescale 1ns/1ps
module ias_address_select_bench
  import ias_pkg::*;
;
  localparam logic [7:0] HOST_DEF[4] = '{8'hc0, 8'ha8, 8'h01, 8'h01};
  localparam logic [7:0] MASK_DEF[4] = '{8'hff, 8'hff, 8'hff, 8'h00};
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]       wb_adr_i = 8'h00, sw = 8'h00;
  logic [3:0]       wb_sel_i = 4'hf;
  logic [31:0]      wb_dat_i = 32'h0, wb_dat_o;
  logic             wb_ack_o, active_valid_o, dhcp_enable_o, duplicate_host_error_o, irq_o;
  logic             offer = 1'b0, announce = 1'b0;
  ias_addr_set_type offer_set = '0, active_o;
  ias_quad_type     announce_ip = '0;
  ias_lease_type    lease;
  ias_peer_type     peer;
  ias_src_type      active_src_o;
  logic [31:0]      expq[$];
  int               failures = 0, n_tests = 0;

  always #2 clk_i = ~clk_i;

  ias_address_select ias_address_select_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .octet_selector_switches_i(sw), .dhcp_lease_i(lease),
    .peer_i(peer), .active_o, .active_valid_o, .active_src_o, .dhcp_enable_o, .duplicate_host_error_o, .irq_o);
  ias_net_model ias_net_model_inst (.clk_i, .rst_i, .dhcp_enable_i(dhcp_enable_o), .offer_i(offer),
    .offer_set_i(offer_set), .announce_i(announce), .announce_ip_i(announce_ip), .lease_o(lease), .peer_o(peer));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One classic cycle; the expected read word is queued for the monitor.
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] exp);
    int k;
    expq.push_back(we ? 32'h0 : exp);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    for (k = 0; k < 20; k++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (k == 20) begin
      failures++;
      conclude();
    end
  endtask

  task automatic power(input logic [7:0] s);
    sw    <= s;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  // One-cycle command to the network model: a lease offer when use_offer is set, else an announcement.
  task automatic pulse(input logic use_offer);
    if (use_offer) offer <= 1'b1;
    else announce <= 1'b1;
    @(posedge clk_i);
    offer    <= 1'b0;
    announce <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1) begin
      if (expq.size() == 0) chk("unexpected ack", 32'h1, 32'h0);
      else chk("wb_dat_o", wb_dat_o, expq.pop_front());
    end
  end

  initial begin
    ias_addr_set_type ls;
    ias_quad_type     hip;
    logic [7:0]       swv[4];
    void'($urandom(32'h77f9));
    ls  = {$urandom, $urandom, $urandom};
    hip = $urandom;
    swv = '{8'h01, 8'hfe, 8'hff, 8'($urandom_range(254, 1))};
    @(posedge clk_i);
    power(8'h00);
    bus(0, IAS_OFF_SEL, 0, 32'h2);
    for (int i = 0; i < 4; i++) begin
      bus(0, IAS_OFF_HOST + 8'(4 * i), 0, {24'h0, HOST_DEF[i]});
      bus(0, IAS_OFF_MASK + 8'(4 * i), 0, {24'h0, MASK_DEF[i]});
      bus(0, IAS_OFF_GW + 8'(4 * i), 0, 32'h0);
    end
    bus(1, 8'h50, 32'hff, 0);
    bus(0, 8'h50, 0, 32'h0);
    chk("dhcp_enable_o", {31'h0, dhcp_enable_o}, 32'h1);
    bus(0, IAS_OFF_INFO, 0, 32'h1);
    bus(1, IAS_OFF_IRQMASK, 32'h2, 0);
    offer_set <= ls;
    pulse(1'b1);
    chk("irq_o", {31'h0, irq_o}, 32'h1);
    bus(0, IAS_OFF_ACT_IP, 0, ls.ip);
    bus(0, IAS_OFF_ACT_MSK, 0, ls.mask);
    bus(0, IAS_OFF_ACT_GW, 0, ls.gw);
    bus(0, IAS_OFF_STATUS, 0, 32'h2);
    chk("irq_o", {31'h0, irq_o}, 32'h0);
    announce_ip <= ls.ip;
    pulse(1'b0);
    chk("duplicate_host_error_o", {31'h0, duplicate_host_error_o}, 32'h1);
    chk("irq_o", {31'h0, irq_o}, 32'h0);
    bus(0, IAS_OFF_STATUS, 0, 32'h1);
    power(8'h00);
    chk("active_valid_o", {31'h0, active_valid_o}, 32'h0);
    bus(1, IAS_OFF_SEL, 32'h0, 0);
    bus(1, IAS_OFF_SEL, 32'h5, 0);
    bus(0, IAS_OFF_SEL, 0, 32'h0);
    for (int i = 0; i < 4; i++) bus(1, IAS_OFF_HOST + 8'(4 * i), {24'h0, hip[3 - i]}, 0);
    bus(0, IAS_OFF_ACT_IP, 0, hip);
    bus(0, IAS_OFF_ACT_MSK, 0, 32'hffffff00);
    chk("dhcp_enable_o", {31'h0, dhcp_enable_o}, 32'h0);
    sw <= 8'h37;
    repeat (4) @(posedge clk_i);
    bus(0, IAS_OFF_ACT_IP, 0, hip);
    power(8'h37);
    bus(0, IAS_OFF_ACT_IP, 0, 32'hc0a80137);
    bus(0, IAS_OFF_ACT_MSK, 0, 32'hffffff00);
    bus(0, IAS_OFF_INFO, 0, 32'h3702);
    chk("active_src_o", {27'h0, active_src_o}, 32'h2);
    chk("active_o.ip", active_o.ip, 32'hc0a80137);
    chk("active_o.mask", active_o.mask, 32'hffffff00);
    foreach (swv[j]) begin
      power(swv[j]);
      bus(1, IAS_OFF_HOST, 32'h0a, 0);
      bus(0, IAS_OFF_ACT_IP, 0, (swv[j] == 8'hff) ? 32'hc0a80101 : {24'h0aa801, swv[j]});
    end
    conclude();
  end
endmodule
